// ===== verilog/rsi_core.v
// Contract
// RQ1 - Core is halted from reset entry until the reset state is exited.
// RQ2 - While reset is asserted all registers load their default values.
// RQ3 - Reset disables every interrupt source and every timer.
// RQ4 - Reset leaves internal data memory contents untouched.
// RQ5 - Reset restores the stack pointer but not the memory it used.
// RQ6 - Reset sets port latches to all ones in open-drain mode.
// RQ7 - Weak pull-ups stay on during and after reset.
// RQ8 - Power-on or supply-monitor reset drives reset pin low until exit.
// RQ9 - Leaving reset clears the program counter and selects internal oscillator.
// RQ10 - Leaving reset starts the watchdog on system clock divided by twelve.
// RQ11 - After reset wait for stable clock, then fetch from address zero.
// RQ12 - Mask bit seven globally gates all interrupt sources.
// RQ13 - Mask bit six is a software flag without interrupt effect.
// RQ14 - Mask bit five gates both timer 2 overflow flags.
// RQ15 - Mask bit four gates the serial port request.
// RQ16 - Mask bit three gates the timer 1 overflow flag.
// RQ17 - Mask bit two gates external interrupt input 1.
// RQ18 - Mask bit one gates the timer 0 overflow flag.
// RQ19 - Mask bit zero gates external interrupt input 0.
// RQ20 - A request needs pending flag, its enable and global enable.
`timescale 1ns/1ns
`default_nettype none
`include "rsi_regs.vh"

module rsi_core #(
  parameter integer STABLE_CYCLES = `RSI_CLK_STABLE_CYCLES,
  parameter integer WDOG_DIV      = `RSI_WDOG_DIV
) (
  // Clock and reset
  input  wire        clk_in,
  input  wire        sys_rst_in,
  // Reset cause, valid while sys_rst_in is high
  input  wire        rst_cause_por_in,
  input  wire        rst_cause_supply_in,
  input  wire        rst_cause_pin_in,
  input  wire        rst_cause_wdog_in,
  input  wire        rst_cause_sw_in,
  // Clock source status
  input  wire        clk_stable_in,
  // Special function register port from the core
  input  wire        sfr_wr_in,
  input  wire        sfr_rd_in,
  input  wire [7:0]  sfr_addr_in,
  input  wire [7:0]  sfr_wdata_in,
  output reg  [7:0]  sfr_rdata_out,
  output reg         sfr_hit_out,
  // Interrupt pending flags from peripherals
  input  wire        ext_irq0_input,
  input  wire        timer0_overflow_flag,
  input  wire        ext_irq1_input,
  input  wire        timer1_overflow_flag,
  input  wire        serial_port_irq_in,
  input  wire        timer2_low_overflow_flag,
  input  wire        timer2_high_overflow_flag,
  // Core control
  output wire        core_halt_out,
  output wire        core_pc_load_out,
  output wire [15:0] core_pc_out,
  output wire [7:0]  stack_ptr_out,
  output wire [5:0]  irq_req_out,
  // Port, clock and watchdog defaults
  output wire [7:0]  port_latch_out,
  output wire [7:0]  port_push_pull_out,
  output wire        weak_pullup_en_out,
  output wire        rst_pin_o_out,
  output wire        rst_pin_oe_out,
  output wire        clk_sel_ext_out,
  output wire        timers_en_out,
  output wire        wdog_en_out,
  output wire        wdog_tick_out
);

  //////////////////////////////////////////////////////////////////////////////
  // Sequencer states.
  localparam [1:0] ST_RESET  = 2'b00;
  localparam [1:0] ST_WAIT   = 2'b01;
  localparam [1:0] ST_LAUNCH = 2'b10;
  localparam [1:0] ST_RUN    = 2'b11;

  reg [1:0]  state_ff;
  reg [1:0]  nxt_state;
  reg [15:0] stable_cnt_ff;
  reg [15:0] nxt_stable_cnt;
  reg        drive_pin_ff;
  reg [7:0]  irq_mask_ff;
  reg [7:0]  stack_ptr_ff;
  reg [7:0]  port_latch_ff;
  reg [7:0]  port_mode_ff;
  reg [7:0]  wdog_mode_ff;
  reg [7:0]  clk_sel_ff;
  reg [4:0]  rst_src_ff;

  //////////////////////////////////////////////////////////////////////////////
  // Reset state sequencing. Registers alone are cleared here; internal data
  // memory lives in the core and is never touched by this block. RQ4
  always @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      state_ff      <= ST_RESET; // RQ1
      stable_cnt_ff <= 16'h0000;
    end else begin
      state_ff      <= nxt_state;
      stable_cnt_ff <= nxt_stable_cnt;
    end
  end

  // The clock must read stable for a run of cycles, since a glitchy stable
  // flag right after a source switch would otherwise start fetch too early.
  always @* begin
    nxt_state      = state_ff;
    nxt_stable_cnt = stable_cnt_ff;
    case (state_ff)
      ST_RESET: begin
        nxt_state      = ST_WAIT;
        nxt_stable_cnt = 16'h0000;
      end
      ST_WAIT: begin
        if (!clk_stable_in) begin
          nxt_stable_cnt = 16'h0000; // RQ11
        end else if (stable_cnt_ff == STABLE_CYCLES[15:0] - 16'h0001) begin
          nxt_state = ST_LAUNCH; // RQ11
        end else begin
          nxt_stable_cnt = stable_cnt_ff + 16'h0001;
        end
      end
      ST_LAUNCH: begin
        nxt_state = ST_RUN;
      end
      ST_RUN: begin
        nxt_state = ST_RUN;
      end
      default: begin
        nxt_state = ST_RESET;
      end
    endcase
  end

  assign core_halt_out    = (state_ff != ST_RUN); // RQ1
  assign core_pc_load_out = (state_ff == ST_LAUNCH); // RQ11
  assign core_pc_out      = `RSI_RST_PC; // RQ9

  //////////////////////////////////////////////////////////////////////////////
  // Reset pin drive. The cause is a level valid only while reset is held, so
  // it is caught on the first clock after release rather than in the reset
  // branch; until then the live cause drives the pin. The drive ends on the
  // launch edge, so the pin is released in the same cycle as the core.
  reg cause_caught_ff;

  always @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      drive_pin_ff    <= 1'b0; // RQ8
      cause_caught_ff <= 1'b0;
      rst_src_ff      <= 5'h00;
    end else begin
      if (!cause_caught_ff) begin
        cause_caught_ff <= 1'b1;
        drive_pin_ff    <= rst_cause_por_in | rst_cause_supply_in; // RQ8
        rst_src_ff      <= {rst_cause_sw_in, rst_cause_wdog_in, rst_cause_supply_in,
                            rst_cause_por_in, rst_cause_pin_in};
      end else if (state_ff == ST_LAUNCH) begin
        drive_pin_ff <= 1'b0; // RQ8
      end
    end
  end

  assign rst_pin_o_out  = 1'b0;
  assign rst_pin_oe_out = drive_pin_ff |
                          ((state_ff == ST_RESET) &
                           (rst_cause_por_in | rst_cause_supply_in)); // RQ8

  //////////////////////////////////////////////////////////////////////////////
  // Register file. All defaults are loaded by the asynchronous reset. RQ2
  wire wr_mask  = sfr_wr_in && (sfr_addr_in == `RSI_ADDR_IRQ_MASK);
  wire wr_sp    = sfr_wr_in && (sfr_addr_in == `RSI_ADDR_STACK_PTR);
  wire wr_latch = sfr_wr_in && (sfr_addr_in == `RSI_ADDR_PORT_LATCH);
  wire wr_mode  = sfr_wr_in && (sfr_addr_in == `RSI_ADDR_PORT_OUT_MODE);
  wire wr_wdog  = sfr_wr_in && (sfr_addr_in == `RSI_ADDR_WDOG_MODE);
  wire wr_clk   = sfr_wr_in && (sfr_addr_in == `RSI_ADDR_CLK_SEL);

  always @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      irq_mask_ff   <= `RSI_RST_IRQ_MASK; // RQ3
      stack_ptr_ff  <= `RSI_RST_STACK_PTR; // RQ5
      port_latch_ff <= `RSI_RST_PORT_LATCH; // RQ6
      port_mode_ff  <= `RSI_RST_PORT_OUT_MODE; // RQ6
      wdog_mode_ff  <= `RSI_RST_WDOG_MODE; // RQ10
      clk_sel_ff    <= `RSI_RST_CLK_SEL; // RQ9
    end else begin
      if (wr_mask) begin
        irq_mask_ff <= sfr_wdata_in; // RQ13
      end
      if (wr_sp) begin
        stack_ptr_ff <= sfr_wdata_in;
      end
      if (wr_latch) begin
        port_latch_ff <= sfr_wdata_in;
      end
      if (wr_mode) begin
        port_mode_ff <= sfr_wdata_in;
      end
      // Watchdog mode is frozen while its enable bit is set, except for a write that clears the enable bit.
      if (wr_wdog && (!wdog_mode_ff[`RSI_BIT_WDOG_EN] ||
                      !sfr_wdata_in[`RSI_BIT_WDOG_EN])) begin
        wdog_mode_ff <= sfr_wdata_in;
      end
      if (wr_clk) begin
        clk_sel_ff <= sfr_wdata_in;
      end
    end
  end

  always @* begin
    sfr_hit_out   = 1'b1;
    sfr_rdata_out = 8'h00;
    case (sfr_addr_in)
      `RSI_ADDR_IRQ_MASK:      sfr_rdata_out = irq_mask_ff;
      `RSI_ADDR_STACK_PTR:     sfr_rdata_out = stack_ptr_ff;
      `RSI_ADDR_PORT_LATCH:    sfr_rdata_out = port_latch_ff;
      `RSI_ADDR_PORT_OUT_MODE: sfr_rdata_out = port_mode_ff;
      `RSI_ADDR_WDOG_MODE:     sfr_rdata_out = wdog_mode_ff;
      `RSI_ADDR_CLK_SEL:       sfr_rdata_out = clk_sel_ff;
      `RSI_ADDR_RST_SRC:       sfr_rdata_out = {3'b000, rst_src_ff};
      default: begin
        sfr_hit_out   = 1'b0;
        sfr_rdata_out = 8'h00;
      end
    endcase
    if (!sfr_rd_in) begin
      sfr_rdata_out = 8'h00;
    end
  end

  assign stack_ptr_out      = stack_ptr_ff;
  assign port_latch_out     = port_latch_ff;
  assign port_push_pull_out = port_mode_ff;
  assign weak_pullup_en_out = 1'b1; // RQ7
  assign clk_sel_ext_out    = clk_sel_ff[0];
  // Timers only count once the core runs; reset holds them off. RQ3
  assign timers_en_out      = (state_ff == ST_RUN);

  //////////////////////////////////////////////////////////////////////////////
  // Watchdog timebase.
  assign wdog_en_out = wdog_mode_ff[`RSI_BIT_WDOG_EN] && (state_ff == ST_RUN); // RQ10

  rsi_div #(
    .DIV (WDOG_DIV)
  ) u_wdog_div (
    .clk_in     (clk_in),
    .sys_rst_in (sys_rst_in),
    .run_in     (wdog_en_out),
    .tick_out   (wdog_tick_out) // RQ10
  );

  //////////////////////////////////////////////////////////////////////////////
  // Interrupt gating, one gate per source in core vector order.
  wire [5:0] irq_pend;
  wire [5:0] irq_en;
  wire       global_en = irq_mask_ff[`RSI_BIT_GLOBAL_EN]; // RQ12

  assign irq_pend = {timer2_low_overflow_flag | timer2_high_overflow_flag, // RQ14
                     serial_port_irq_in, timer1_overflow_flag, ext_irq1_input,
                     timer0_overflow_flag, ext_irq0_input};
  assign irq_en   = {irq_mask_ff[`RSI_BIT_TIMER2_EN], // RQ14
                     irq_mask_ff[`RSI_BIT_SERIAL_EN], // RQ15
                     irq_mask_ff[`RSI_BIT_TIMER1_EN], // RQ16
                     irq_mask_ff[`RSI_BIT_EXT1_EN], // RQ17
                     irq_mask_ff[`RSI_BIT_TIMER0_EN], // RQ18
                     irq_mask_ff[`RSI_BIT_EXT0_EN]}; // RQ19

  genvar gi;
  generate
    for (gi = 0; gi < 6; gi = gi + 1) begin : g_irq
      rsi_gate u_gate (
        .pend_in      (irq_pend[gi]),
        .src_en_in    (irq_en[gi]),
        .global_en_in (global_en),
        .req_out      (irq_req_out[gi]) // RQ20
      );
    end
  endgenerate

endmodule

`default_nettype wire

// ===== include/rsi_regs.vh
`ifndef RSI_REGS_VH
`define RSI_REGS_VH

// Special function register addresses.
`define RSI_ADDR_IRQ_MASK      8'hA8
`define RSI_ADDR_RST_SRC       8'hEF
`define RSI_ADDR_STACK_PTR     8'h81
`define RSI_ADDR_PORT_LATCH    8'h80
`define RSI_ADDR_PORT_OUT_MODE 8'hA4
`define RSI_ADDR_WDOG_MODE     8'hD9
`define RSI_ADDR_CLK_SEL       8'hB2

// Reset values.
`define RSI_RST_IRQ_MASK       8'h00
`define RSI_RST_STACK_PTR      8'h07
`define RSI_RST_PORT_LATCH     8'hFF
`define RSI_RST_PORT_OUT_MODE  8'h00
`define RSI_RST_WDOG_MODE      8'h40
`define RSI_RST_CLK_SEL        8'h00
`define RSI_RST_PC             16'h0000

// Interrupt mask field positions.
`define RSI_BIT_GLOBAL_EN      7
`define RSI_BIT_SW_FLAG        6
`define RSI_BIT_TIMER2_EN      5
`define RSI_BIT_SERIAL_EN      4
`define RSI_BIT_TIMER1_EN      3
`define RSI_BIT_EXT1_EN        2
`define RSI_BIT_TIMER0_EN      1
`define RSI_BIT_EXT0_EN        0

// Reset source status fields.
`define RSI_BIT_SRC_PIN        0
`define RSI_BIT_SRC_POR        1
`define RSI_BIT_SRC_SUPPLY     2
`define RSI_BIT_SRC_WDOG       3
`define RSI_BIT_SRC_SW         4

// Watchdog mode fields, watchdog divider and clock-stable cycle count.
`define RSI_BIT_WDOG_EN        6
`define RSI_WDOG_DIV           12
`define RSI_CLK_STABLE_CYCLES  16

`endif

// ===== verilog/rsi_div.v
`timescale 1ns/1ns
`default_nettype none

// Divider producing a one-cycle tick every DIV clocks while run_in is high; held cleared otherwise.
module rsi_div #(
  parameter integer DIV = 12
) (
  // Clock and reset
  input  wire clk_in,
  input  wire sys_rst_in,
  // Control
  input  wire run_in,
  // Tick
  output reg  tick_out
);

  reg [7:0] cnt_ff;

  always @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      cnt_ff   <= 8'h00;
      tick_out <= 1'b0;
    end else if (!run_in) begin
      cnt_ff   <= 8'h00;
      tick_out <= 1'b0;
    end else if (cnt_ff == DIV[7:0] - 8'h01) begin
      cnt_ff   <= 8'h00;
      tick_out <= 1'b1;
    end else begin
      cnt_ff   <= cnt_ff + 8'h01;
      tick_out <= 1'b0;
    end
  end

endmodule

`default_nettype wire

// ===== verilog/rsi_gate.v
`timescale 1ns/1ns
`default_nettype none

// One interrupt source: pending flag qualified by its own and the global enable.
module rsi_gate (
  // Inputs
  input  wire pend_in,
  input  wire src_en_in,
  input  wire global_en_in,
  // Request
  output wire req_out
);

  assign req_out = pend_in & src_en_in & global_en_in;

endmodule

`default_nettype wire

// ===== testbench/rsi_chk.sv
`timescale 1ns/1ns
`default_nettype none
module rsi_chk #(
  parameter integer STABLE_CYCLES = 16
) (
  input wire logic clk_in, sys_rst_in, clk_stable_in, sfr_wr_in, sfr_rd_in,
  input wire logic [7:0] sfr_addr_in, sfr_wdata_in, sfr_rdata_out,
  input wire logic sfr_hit_out, ext_irq0_input, timer0_overflow_flag, ext_irq1_input,
  input wire logic timer1_overflow_flag, serial_port_irq_in, timer2_low_overflow_flag,
  input wire logic timer2_high_overflow_flag, core_halt_out, core_pc_load_out,
  input wire logic [15:0] core_pc_out,
  input wire logic [5:0] irq_req_out,
  input wire logic weak_pullup_en_out, rst_pin_o_out, rst_pin_oe_out, timers_en_out,
  input wire logic wdog_en_out, wdog_tick_out
);
  logic [7:0] mask_ff;
  logic [7:0] stab_ff;
  logic [5:0] want;
  // Shadow of the mask, so requests can be judged from the port traffic alone.
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      mask_ff <= 8'h00;
      stab_ff <= 8'h00;
    end else begin
      if (sfr_wr_in && sfr_addr_in == 8'hA8)
        mask_ff <= sfr_wdata_in;
      stab_ff <= clk_stable_in ? stab_ff + {7'h00, stab_ff != 8'hFF} : 8'h00;
    end
  end
  assign want = {6{mask_ff[7]}} & mask_ff[5:0] & {timer2_low_overflow_flag |
    timer2_high_overflow_flag, serial_port_irq_in, timer1_overflow_flag,
    ext_irq1_input, timer0_overflow_flag, ext_irq0_input};
  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  property p_gate; irq_req_out == want; endproperty
  a_gate: assert property (p_gate) else $error("irq request mismatch");
  property p_global; !mask_ff[7] |-> irq_req_out == 6'h00; endproperty
  a_global: assert property (p_global) else $error("request without global");
  property p_launch; core_pc_load_out |-> core_halt_out && core_pc_out == 16'h0000; endproperty
  a_launch: assert property (p_launch) else $error("bad launch");
  property p_run; core_pc_load_out |=> !core_halt_out; endproperty
  a_run: assert property (p_run) else $error("core not released");
  property p_wait; core_pc_load_out |-> stab_ff >= STABLE_CYCLES - 1; endproperty
  a_wait: assert property (p_wait) else $error("launch before clock stable");
  property p_halt; core_halt_out |-> !timers_en_out && !wdog_en_out; endproperty
  a_halt: assert property (p_halt) else $error("timer on while halted");
  property p_pin; rst_pin_oe_out |-> core_halt_out && !rst_pin_o_out; endproperty
  a_pin: assert property (p_pin) else $error("reset pin driven after exit");
  property p_pull; weak_pullup_en_out; endproperty
  a_pull: assert property (p_pull) else $error("pull-ups off");
  property p_tick; wdog_tick_out |=> !wdog_tick_out [*8]; endproperty
  a_tick: assert property (p_tick) else $error("watchdog tick too early");
  property p_tick_due; $rose(wdog_en_out) |-> ##[1:13] wdog_tick_out; endproperty
  a_tick_due: assert property (p_tick_due) else $error("watchdog tick missing");
  property p_wdog_on; core_pc_load_out |=> wdog_en_out; endproperty
  a_wdog_on: assert property (p_wdog_on) else $error("watchdog off at exit");
  c_launch: cover property (core_pc_load_out);
  c_irq: cover property (irq_req_out != 6'h00);
  c_pin: cover property (rst_pin_oe_out && core_pc_load_out);
endmodule
bind rsi_core rsi_chk #(.STABLE_CYCLES(STABLE_CYCLES)) chk (.clk_in, .sys_rst_in,
  .clk_stable_in, .sfr_wr_in, .sfr_rd_in, .sfr_addr_in, .sfr_wdata_in, .sfr_rdata_out,
  .sfr_hit_out, .ext_irq0_input, .timer0_overflow_flag, .ext_irq1_input,
  .timer1_overflow_flag, .serial_port_irq_in, .timer2_low_overflow_flag,
  .timer2_high_overflow_flag, .core_halt_out, .core_pc_load_out, .core_pc_out,
  .irq_req_out, .weak_pullup_en_out, .rst_pin_o_out, .rst_pin_oe_out, .timers_en_out,
  .wdog_en_out, .wdog_tick_out);
`default_nettype wire

// ===== testbench/rsi_peer.sv
`timescale 1ns/1ns
`default_nettype none
// Peripherals: pending flags can only rise while the core runs.
module rsi_peer (
  input  wire logic       clk_in,
  input  wire logic       sys_rst_in,
  input  wire logic       core_halt_in,
  input  wire logic [6:0] pend_in,
  output var  logic [6:0] flag_out
);
  logic [6:0] flag_ff;
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in)
      flag_ff <= 7'h00;
    else
      flag_ff <= pend_in & {7{!core_halt_in}};
  end
  assign flag_out = flag_ff;
endmodule
`default_nettype wire

// ===== testbench/testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic clk_stable_in = 1'b0;
  logic sfr_wr_in = 1'b0;
  logic sfr_rd_in = 1'b0;
  logic obs = 1'b0;
  logic [4:0] cause = 5'h00;
  logic [6:0] pend = 7'h00;
  logic [7:0] sfr_addr_in = 8'h00;
  logic [7:0] sfr_wdata_in = 8'h00;
  logic [6:0] flag;
  logic [7:0] rdata, latch, m, f, sp, pp;
  logic [15:0] pc, mexp;
  logic [5:0] irq, ex;
  logic [3:0] msel;
  logic halt, load, hit, oe, pull, cs;
  logic [19:0] q[$];
  logic [31:0] seed = 32'hC2A0;
  int num_errors = 0;
  int compares = 0;
  logic [7:0] ra [7] = '{8'hA8, 8'h81, 8'h80, 8'hA4, 8'hD9, 8'hB2, 8'h90};
  logic [7:0] rv [7] = '{8'h00, 8'h07, 8'hFF, 8'h00, 8'h40, 8'h00, 8'h00};
  always #4 clk_in = ~clk_in;
  rsi_core #(.STABLE_CYCLES(2)) dut (.clk_in, .sys_rst_in, .rst_cause_pin_in(cause[0]),
    .rst_cause_por_in(cause[1]), .rst_cause_supply_in(cause[2]), .rst_cause_wdog_in(cause[3]),
    .rst_cause_sw_in(cause[4]), .clk_stable_in, .sfr_wr_in, .sfr_rd_in, .sfr_addr_in,
    .sfr_wdata_in, .sfr_rdata_out(rdata), .sfr_hit_out(hit), .ext_irq0_input(flag[0]),
    .timer0_overflow_flag(flag[1]), .ext_irq1_input(flag[2]), .timer1_overflow_flag(flag[3]),
    .serial_port_irq_in(flag[4]), .timer2_low_overflow_flag(flag[5]),
    .timer2_high_overflow_flag(flag[6]), .core_halt_out(halt), .core_pc_load_out(load),
    .core_pc_out(pc), .stack_ptr_out(sp), .irq_req_out(irq), .port_latch_out(latch),
    .port_push_pull_out(pp), .weak_pullup_en_out(pull), .rst_pin_o_out(), .rst_pin_oe_out(oe),
    .clk_sel_ext_out(cs), .timers_en_out(), .wdog_en_out(), .wdog_tick_out());
  rsi_peer peer (.clk_in, .sys_rst_in, .core_halt_in(halt), .pend_in(pend), .flag_out(flag));
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
    end
  endtask
  task automatic wrap_up();
    $display("compares %0d, errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // Results are taken at the falling edge, after the rising edge has settled.
  always @(negedge clk_in) begin
    if ((obs || load === 1'b1) && q.size() > 0) begin
      {msel, mexp} = q.pop_front();
      case (msel)
        4'h0: check("read data", {8'h00, rdata}, mexp);
        4'h1: check("irq request", {10'h000, irq}, mexp);
        4'h2: check("halt", {15'h0000, halt}, mexp);
        4'h3: check("pc", pc, mexp);
        4'h4: check("reset pin drive", {15'h0000, oe}, mexp);
        4'h5: check("hit", {15'h0000, hit}, mexp);
        4'h6: check("pull-up", {15'h0000, pull}, mexp);
        4'h8: check("stack pointer", {8'h00, sp}, mexp);
        4'h9: check("push-pull mode", {8'h00, pp}, mexp);
        4'hA: check("clock select", {15'h0000, cs}, mexp);
        default: check("port latch", {8'h00, latch}, mexp);
      endcase
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    sfr_wr_in <= 1'b1;
    sfr_addr_in <= a;
    sfr_wdata_in <= d;
    @(posedge clk_in);
    sfr_wr_in <= 1'b0;
  endtask
  task automatic note(input logic [3:0] s, input logic [15:0] e, input logic [7:0] a);
    @(posedge clk_in);
    sfr_rd_in <= 1'b1;
    sfr_addr_in <= a;
    obs <= 1'b1;
    q.push_back({s, e});
    @(posedge clk_in);
    sfr_rd_in <= 1'b0;
    obs <= 1'b0;
  endtask
  task automatic do_reset(input logic [4:0] c);
    @(posedge clk_in);
    sys_rst_in <= 1'b1;
    cause <= c;
    clk_stable_in <= 1'b0;
    repeat (4) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    repeat (3) @(posedge clk_in);
    note(4'h4, {15'h0000, c[1] | c[2]}, 8'h00);
    clk_stable_in <= 1'b1;
    q.push_back({4'h3, 16'h0000});
    for (int i = 0; i < 100 && load !== 1'b1; i++) @(negedge clk_in);
    if (load !== 1'b1) begin
      num_errors++;
      wrap_up();
    end
    note(4'h2, 16'h0000, 8'h00);
    note(4'h4, 16'h0000, 8'h00);
  endtask
  initial begin
    repeat (4) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    for (int k = 0; k < 5; k++) begin
      for (int i = 0; i < 6; i++) wr(ra[i], xs());
      do_reset(5'h01 << k);
      for (int i = 0; i < 7; i++) note(4'h0, {8'h00, rv[i]}, ra[i]);
      note(4'h0, {11'h000, 5'h01} << k, 8'hEF);
      note(4'h5, 16'h0000, 8'h90);
      note(4'h6, 16'h0001, 8'h00);
      note(4'h7, 16'h00FF, 8'h00);
      note(4'h8, 16'h0007, 8'h00);
      note(4'h9, 16'h0000, 8'h00);
      note(4'hA, 16'h0000, 8'h00);
      note(4'h5, 16'h0001, 8'hA8);
      $display("reset cause %0d test done", k);
    end
    for (int n = 0; n < 48; n++) begin
      m = xs();
      f = xs();
      pend <= f[6:0];
      wr(8'hA8, m);
      ex = {6{m[7]}} & m[5:0] & {f[5] | f[6], f[4:0]};
      note(4'h1, {10'h000, ex}, 8'hA8);
      note(4'h0, {8'h00, m}, 8'hA8);
    end
    $display("mask test done");
    wrap_up();
  end
endmodule
`default_nettype wire
